// *** rtl/flash_prog_pkg.sv ***
package flash_prog_pkg;

   // ****************************************************************
   // array geometry
   // ****************************************************************
   localparam int ADDR_W      = 13;          // 8 Kbyte array
   localparam int DATA_W      = 8;           // one byte per word
   localparam int PAGE_BYTES  = 16;          // bytes per programming cycle
   localparam int PAGE_IDX_W  = 4;
   localparam logic [15:0] ARRAY_BASE = 16'he000; // top of the address space
   localparam logic [7:0]  ERASED_BYTE = 8'hff;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_NS        = 8;
   localparam int PROG_TIME_NS  = 2000;      // per programming cycle
   localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int SEL_PULSES    = 4;         // select edges that open the mode

   // ****************************************************************
   // serial command codes
   // ****************************************************************
   localparam logic [7:0] CMD_RAM_EXEC = 8'h01;
   localparam logic [7:0] CMD_LOAD     = 8'h02;
   localparam logic [7:0] CMD_RUN      = 8'h03;

   typedef enum logic [1:0] {
      PH_IDLE, PH_RAM_EXEC, PH_LOAD, PH_RUN
   } phase_e;

   typedef struct packed {
      logic                 valid;
      logic [ADDR_W-1:0]    addr;
      logic [DATA_W-1:0]    data;
   } byte_wr_s;

endpackage : flash_prog_pkg

// *** rtl/flash_remote_prog_protect.sv ***
`timescale 1ns/10ps
module flash_remote_prog_protect
   import flash_prog_pkg::*;
#(
   parameter int PROG_CNT = PROG_CYCLES
) (
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   // cpu side
   input  wire logic [15:0]                  cpuAddr,
   input  wire logic                         cpuRead,
   output logic [flash_prog_pkg::DATA_W-1:0] cpuRdata,
   output logic                              cpuHit,
   input  wire flash_prog_pkg::byte_wr_s     cpuWrite,
   input  wire logic                         cpuCommit,
   input  wire logic                         externalRead,
   // protection option
   input  wire logic                         protectSet,
   input  wire logic                         protectClear,
   output logic                              protectActive,
   // remote programming pins
   input  wire logic                         remote_prog_select,
   input  wire logic                         remote_prog_clock,
   input  wire logic                         remote_prog_data,
   output flash_prog_pkg::phase_e            phase,
   output logic                              busy,
   output logic                              writeRefused
);
   import flash_prog_pkg::*;

   // ****************************************************************
   // storage and page buffer
   // ****************************************************************
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] pageData [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pageUsed, next_pageUsed;
   logic [ADDR_W-1:PAGE_IDX_W] pageBase, next_pageBase;

   typedef enum logic [1:0] {S_IDLE, S_PROG, S_ERASE} op_e;
   op_e              op, next_op;
   logic [15:0]      timer, next_timer;
   logic [ADDR_W-1:0] eraseAddr, next_eraseAddr;
   logic             next_protect;
   logic             next_writeRefused;
   logic             latchEn;            // byte accepted into the page latch

   // ****************************************************************
   // remote select detection and phases
   // ****************************************************************
   logic [1:0] selSync, next_selSync;
   logic       selPrev, next_selPrev;
   logic [2:0] selCnt,  next_selCnt;
   phase_e     next_phase;
   logic       rxValid;
   logic [7:0] rxData;
   logic [1:0] loadCnt, next_loadCnt;
   logic [ADDR_W-1:0] loadAddr, next_loadAddr;
   byte_wr_s   remWr;

   // serial link receiver, active once the mode is entered
   serial_rx u_rx (
      .clk       (clk),
      .rst_b     (rst_b),
      .enable    (phase != PH_IDLE),
      .linkClk   (remote_prog_clock),
      .linkData  (remote_prog_data),
      .byteValid (rxValid),
      .byteData  (rxData)
   );

   // select pulse counting and phase sequencing
   always_comb begin
      next_selSync  = {selSync[0], remote_prog_select};
      next_selPrev  = selSync[1];
      next_selCnt   = selCnt;
      next_phase    = phase;
      next_loadCnt  = loadCnt;
      next_loadAddr = loadAddr;
      remWr         = '0;
      if (phase == PH_IDLE && selSync[1] && !selPrev) begin
         next_selCnt = selCnt + 3'h1;
         if (selCnt == 3'(SEL_PULSES - 1)) begin
            next_phase  = PH_RAM_EXEC;
            next_selCnt = 3'h0;
         end
      end
      if (rxValid) begin
         unique case (phase)
            PH_IDLE: ;
            PH_RAM_EXEC:
               if (rxData == CMD_LOAD) next_phase = PH_LOAD;
            PH_LOAD:
               if (rxData == CMD_RUN) next_phase = PH_RUN;
            PH_RUN: begin
               // two address bytes, data bytes, run byte commits
               if (loadCnt == 2'h0) begin
                  next_loadAddr = {rxData[ADDR_W-9:0], 8'h00};
                  next_loadCnt  = 2'h1;
               end else if (loadCnt == 2'h1) begin
                  next_loadAddr = {loadAddr[ADDR_W-1:8], rxData};
                  next_loadCnt  = 2'h2;
               end else if (rxData == CMD_RUN) begin
                  next_loadCnt  = 2'h0;                // commit, new address
               end else begin
                  remWr.valid   = 1'b1;
                  remWr.addr    = loadAddr;
                  remWr.data    = rxData;
                  next_loadAddr = loadAddr + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         selSync  <= 2'h0;
         selPrev  <= 1'b0;
         selCnt   <= 3'h0;
         phase    <= PH_IDLE;
         loadCnt  <= 2'h0;
         loadAddr <= '0;
      end else begin
         selSync  <= next_selSync;
         selPrev  <= next_selPrev;
         selCnt   <= next_selCnt;
         phase    <= next_phase;
         loadCnt  <= next_loadCnt;
         loadAddr <= next_loadAddr;
      end
   end

   // ****************************************************************
   // programming, erase and protection control
   // ****************************************************************
   byte_wr_s wr;
   logic     commit;
   assign wr     = remWr.valid ? remWr : cpuWrite;
   assign commit = cpuCommit || (phase == PH_RUN && rxValid
                   && rxData == CMD_RUN && loadCnt == 2'h2);
   assign busy   = (op != S_IDLE);

   always_comb begin
      next_op           = op;
      next_timer        = timer;
      next_pageUsed     = pageUsed;
      next_pageBase     = pageBase;
      next_eraseAddr    = eraseAddr;
      next_protect      = protectActive;
      next_writeRefused = 1'b0;
      latchEn           = 1'b0;
      unique case (op)
         S_IDLE: begin
            if (protectActive && protectClear) begin
               next_op        = S_ERASE;
               next_eraseAddr = '0;
            end else if (protectSet) begin
               next_protect = 1'b1;
            end else if (wr.valid && protectActive) begin
               next_writeRefused = 1'b1;
            end else if (wr.valid) begin
               if (pageUsed == '0) next_pageBase = wr.addr[ADDR_W-1:4];
               if (pageUsed == '0 || wr.addr[ADDR_W-1:4] == pageBase) begin
                  next_pageUsed[wr.addr[3:0]] = 1'b1;
                  latchEn = 1'b1;
               end else begin
                  next_writeRefused = 1'b1;
               end
            end else if (commit && pageUsed != '0) begin
               next_op    = S_PROG;
               next_timer = 16'(PROG_CNT - 1);
            end
         end
         S_PROG: begin
            next_timer = timer - 16'h1;
            if (timer == 16'h0) begin
               next_op       = S_IDLE;
               next_pageUsed = '0;
            end
         end
         S_ERASE: begin
            next_eraseAddr = eraseAddr + 1'b1;
            if (eraseAddr == '1) begin
               next_op      = S_IDLE;
               next_protect = 1'b0;
            end
         end
         default: next_op = S_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         op            <= S_IDLE;
         timer         <= 16'h0;
         pageUsed      <= '0;
         pageBase      <= '0;
         eraseAddr     <= '0;
         protectActive <= 1'b0;
         writeRefused  <= 1'b0;
      end else begin
         op            <= next_op;
         timer         <= next_timer;
         pageUsed      <= next_pageUsed;
         pageBase      <= next_pageBase;
         eraseAddr     <= next_eraseAddr;
         protectActive <= next_protect;
         writeRefused  <= next_writeRefused;
      end
   end

   // page latch and array update, one latch per byte slot
   generate
      for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_page
         always_ff @(posedge clk) begin
            // a refused byte must not overwrite the latched one
            if (latchEn && wr.addr[3:0] == 4'(i))
               pageData[i] <= wr.data;
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (op == S_ERASE)
         mem[eraseAddr] <= ERASED_BYTE;
      else if (op == S_PROG && timer == 16'h0) begin
         for (int j = 0; j < PAGE_BYTES; j++)
            if (pageUsed[j])
               mem[{pageBase, 4'(j)}] <= pageData[j];
      end
   end

   // ****************************************************************
   // read port at the top of the address space
   // ****************************************************************
   logic hit;
   assign hit = (cpuAddr >= ARRAY_BASE);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cpuRdata <= 8'h00;
         cpuHit   <= 1'b0;
      end else begin
         cpuHit <= cpuRead && hit;
         if (cpuRead && hit && !(protectActive && externalRead) && !busy)
            cpuRdata <= mem[cpuAddr[ADDR_W-1:0]];
         else
            cpuRdata <= 8'h00;
      end
   end

endmodule : flash_remote_prog_protect

// *** rtl/serial_rx.sv ***
`timescale 1ns/10ps
// ****************************************************************
// serial byte receiver on the remote programming link
// ****************************************************************
module serial_rx (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       enable,
   input  wire logic       linkClk,
   input  wire logic       linkData,
   output logic            byteValid,
   output logic [7:0]      byteData
);
   import flash_prog_pkg::*;

   logic [1:0] clkSync, next_clkSync;
   logic [1:0] datSync, next_datSync;
   logic       clkPrev, next_clkPrev;
   logic [2:0] bitCnt,  next_bitCnt;
   logic [7:0] shift,   next_shift;
   logic       next_byteValid;
   logic [7:0] next_byteData;

   // synchronise pins and shift on rising link clock edges
   always_comb begin
      next_clkSync   = {clkSync[0], linkClk};
      next_datSync   = {datSync[0], linkData};
      next_clkPrev   = clkSync[1];
      next_bitCnt    = bitCnt;
      next_shift     = shift;
      next_byteValid = 1'b0;
      next_byteData  = byteData;
      if (!enable) begin
         next_bitCnt = 3'h0;
      end else if (clkSync[1] && !clkPrev) begin
         next_shift  = {shift[6:0], datSync[1]};  // msb first
         next_bitCnt = bitCnt + 3'h1;
         if (bitCnt == 3'h7) begin
            next_byteValid = 1'b1;
            next_byteData  = {shift[6:0], datSync[1]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         clkSync   <= 2'h0;
         datSync   <= 2'h0;
         clkPrev   <= 1'b0;
         bitCnt    <= 3'h0;
         shift     <= 8'h00;
         byteValid <= 1'b0;
         byteData  <= 8'h00;
      end else begin
         clkSync   <= next_clkSync;
         datSync   <= next_datSync;
         clkPrev   <= next_clkPrev;
         bitCnt    <= next_bitCnt;
         shift     <= next_shift;
         byteValid <= next_byteValid;
         byteData  <= next_byteData;
      end
   end

endmodule : serial_rx

// *** testbench/flash_prog_assertions.sv ***
`timescale 1ns/10ps
// ****************************************************************
// port checks for the flash block
// ****************************************************************
module flash_prog_assertions
   import flash_prog_pkg::*;
#(
   parameter int PROG_CNT = PROG_CYCLES
) (
   input wire logic                         clk,
   input wire logic                         rst_b,
   input wire logic [15:0]                  cpuAddr,
   input wire logic                         cpuRead,
   input wire logic [flash_prog_pkg::DATA_W-1:0] cpuRdata,
   input wire logic                         cpuHit,
   input wire flash_prog_pkg::byte_wr_s     cpuWrite,
   input wire logic                         cpuCommit,
   input wire logic                         externalRead,
   input wire logic                         protectClear,
   input wire logic                         protectActive,
   input wire flash_prog_pkg::phase_e       phase,
   input wire logic                         busy,
   input wire logic                         writeRefused
);
   localparam int PROG_LIM = PROG_CNT + 3;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // latched bytes followed by a commit start a programming cycle
   sequence latchCommit;
      cpuWrite.valid && !protectActive && !busy ##1 cpuCommit;
   endsequence
   sequence progRun;
      busy [*3] ##[1:PROG_LIM] !busy;
   endsequence
   chk_prog_busy: assert property (latchCommit |=> progRun)
      else $error("programming busy window wrong");
   chk_refuse_write: assert property (protectActive && cpuWrite.valid |=> writeRefused)
      else $error("write not refused while protected");
   chk_read_blocked: assert property (protectActive && externalRead && cpuRead |=> cpuRdata == '0)
      else $error("protected data read out");
   chk_low_miss: assert property (cpuRead && cpuAddr < ARRAY_BASE |=> !cpuHit && cpuRdata == '0)
      else $error("hit below the array");
   chk_top_hit: assert property (cpuRead && !busy && !protectActive && cpuAddr >= ARRAY_BASE |=> cpuHit)
      else $error("miss inside the array");
   chk_erase_start: assert property (protectClear && protectActive |=> busy)
      else $error("erase did not start");
   chk_hold_protect: assert property ($fell(protectActive) |-> $past(busy) || $past(busy, 2))
      else $error("protection dropped before erase end");
   chk_busy_blank: assert property (cpuRead && busy |=> cpuRdata == '0)
      else $error("data read while busy");
   chk_phase_step: assert property ($changed(phase) && phase != PH_IDLE |-> 2'(phase) - 2'($past(phase)) == 2'h1)
      else $error("phase skipped a step");
endmodule : flash_prog_assertions

bind flash_remote_prog_protect flash_prog_assertions #(
   .PROG_CNT(PROG_CNT)
) i_flash_prog_assertions (
   .clk(clk), .rst_b(rst_b), .cpuAddr(cpuAddr), .cpuRead(cpuRead),
   .cpuRdata(cpuRdata), .cpuHit(cpuHit), .cpuWrite(cpuWrite),
   .cpuCommit(cpuCommit), .externalRead(externalRead),
   .protectClear(protectClear), .protectActive(protectActive),
   .phase(phase), .busy(busy), .writeRefused(writeRefused)
);

// *** testbench/remote_prog_tool.sv ***
`timescale 1ns/10ps
// ****************************************************************
// programming tool on the far side of the remote link
// ****************************************************************
module remote_prog_tool
   import flash_prog_pkg::*;
(
   output logic selectPin,
   output logic linkClk,
   output logic linkData
);
   localparam time HALF = 80ns;
   // select idles low by its pull-down, clock stands still
   initial begin
      selectPin = 1'b0;
      linkClk = 1'b0;
      linkData = 1'b1;
   end
   // select pulses that open the mode
   task automatic enterMode();
      repeat (SEL_PULSES) begin
         #HALF selectPin = 1'b1;
         #HALF selectPin = 1'b0;
      end
   endtask : enterMode
   // one byte msb first, clocked only inside the frame
   task automatic sendByte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         linkData = b[i];
         #HALF linkClk = 1'b1;
         #HALF linkClk = 1'b0;
      end
      linkData = ~b[0]; // released line must not keep its value
   endtask : sendByte
endmodule : remote_prog_tool

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import flash_prog_pkg::*;
   typedef struct packed {
      logic [15:0] addr; logic wr; logic [7:0] data; logic hit; logic [7:0] rd;
   } row_s;
   logic clk = 0, rst_b = 0, cpuRead = 0, cpuCommit = 0, externalRead = 0;
   logic protectSet = 0, protectClear = 0, cpuHit, protectActive, busy;
   logic writeRefused, selPin, lnkClk, lnkData, hitSeen, refSeen;
   logic [15:0] cpuAddr = '0;
   logic [7:0]  cpuRdata, rd;
   byte_wr_s    cpuWrite = '0;
   phase_e      phase;
   int          failures = 0, n_checks = 0;
   row_s        rows[5] = '{'{16'he000, 1, 8'h5a, 1, 8'h5a},
      '{16'hfffe, 1, 8'h12, 1, 8'h12}, '{16'hffff, 1, 8'hc3, 1, 8'hc3},
      '{16'h0080, 0, 8'h00, 0, 8'h00}, '{16'hdfff, 0, 8'h00, 0, 8'h00}};
   always #4 clk = ~clk;
   flash_remote_prog_protect #(.PROG_CNT(4)) i_flash_remote_prog_protect (
      .clk(clk), .rst_b(rst_b), .cpuAddr(cpuAddr), .cpuRead(cpuRead),
      .cpuRdata(cpuRdata), .cpuHit(cpuHit), .cpuWrite(cpuWrite),
      .cpuCommit(cpuCommit), .externalRead(externalRead),
      .protectSet(protectSet), .protectClear(protectClear),
      .protectActive(protectActive), .remote_prog_select(selPin),
      .remote_prog_clock(lnkClk), .remote_prog_data(lnkData), .phase(phase),
      .busy(busy), .writeRefused(writeRefused));
   remote_prog_tool i_remote_prog_tool (
      .selectPin(selPin), .linkClk(lnkClk), .linkData(lnkData));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic latch(input logic [15:0] a, input logic [7:0] d);
      cpuWrite <= '{1'b1, a[12:0], d};
      @(posedge clk);
   endtask : latch
   task automatic waitIdle(input int n);
      repeat (2) @(negedge clk);
      for (int i = 0; i < n && busy !== 1'b0; i++) @(negedge clk);
      check("busy", busy, 1'b0);
      @(posedge clk);
   endtask : waitIdle
   task automatic commitWait();
      cpuWrite <= '0;
      cpuCommit <= 1'b1;
      @(posedge clk);
      cpuCommit <= 1'b0;
      waitIdle(50);
   endtask : commitWait
   task automatic readAt(input logic [15:0] a);
      cpuAddr <= a;
      cpuRead <= 1'b1;
      @(posedge clk);
      cpuRead <= 1'b0;
      @(negedge clk);
      rd = cpuRdata;
      hitSeen = cpuHit;
      @(posedge clk);
   endtask : readAt
   task automatic pulseNeg();
      cpuWrite <= '0;
      @(negedge clk);
      refSeen = writeRefused;
      @(posedge clk);
   endtask : pulseNeg
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // ****************************************************************
   // watchdog and main sequence
   // ****************************************************************
   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      check("phase", phase, PH_IDLE);
      check("protect", protectActive, 1'b0);
      $display("test reset done");
      @(posedge clk);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            latch(rows[i].addr, rows[i].data);
            commitWait();
         end
         readAt(rows[i].addr);
         check("rdata", rd, rows[i].rd);
         check("hit", hitSeen, rows[i].hit);
      end
      $display("test table done");
      for (int i = 0; i < PAGE_BYTES; i++) latch(16'he100 + 16'(i), 8'h30 + 8'(i));
      commitWait();
      for (int i = 0; i < PAGE_BYTES; i++) begin
         readAt(16'he100 + 16'(i));
         check("page", rd, 8'h30 + 8'(i));
      end
      latch(16'he200, 8'ha5);
      latch(16'he210, 8'h5a);
      pulseNeg();
      check("refused", refSeen, 1'b1);
      commitWait();
      readAt(16'he200);
      check("kept", rd, 8'ha5);
      $display("test page done");
      protectSet <= 1'b1;
      @(posedge clk);
      protectSet <= 1'b0;
      externalRead <= 1'b1;
      readAt(16'he000);
      check("blocked", rd, 8'h00);
      externalRead <= 1'b0;
      latch(16'he000, 8'h00);
      pulseNeg();
      check("refused", refSeen, 1'b1);
      @(posedge clk);
      protectClear <= 1'b1;
      @(posedge clk);
      protectClear <= 1'b0;
      repeat (100) @(negedge clk);
      check("erasing", {busy, protectActive}, 2'b11);
      waitIdle(9000);
      check("protect", protectActive, 1'b0);
      readAt(16'hfffe);
      check("erased", rd, ERASED_BYTE);
      $display("test protect done");
      i_remote_prog_tool.enterMode();
      repeat (8) @(posedge clk);
      check("phase", phase, PH_RAM_EXEC);
      i_remote_prog_tool.sendByte(CMD_LOAD);
      repeat (8) @(posedge clk);
      check("phase", phase, PH_LOAD);
      i_remote_prog_tool.sendByte(CMD_RUN);
      repeat (8) @(posedge clk);
      check("phase", phase, PH_RUN);
      i_remote_prog_tool.sendByte(8'he0);
      i_remote_prog_tool.sendByte(8'h10);
      i_remote_prog_tool.sendByte(8'h77);
      i_remote_prog_tool.sendByte(CMD_RUN);
      @(posedge clk);
      waitIdle(200);
      readAt(16'he010);
      check("remote", rd, 8'h77);
      $display("test remote done");
      results();
   end
endmodule : tb_top
